// file: common/lsr_map.svh
// What this block does
// - Two battery voltage codes, reset to zero
// - Transistor one and two current codes
// - Extended option drops offset from one, two
// - Transistor three and four fine current codes
// - Transistor five and six current codes
// - Converter period is code times step
// - Period bit six reads one, ignores writes
// - Selector picks transistor for power readout
`ifndef LSR_MAP_SVH
`define LSR_MAP_SVH

// ****************************************************************
// Register indexes; the byte address is four times the index.
// ****************************************************************
`define LSR_IDX_BATT_A      8'h52
`define LSR_IDX_BATT_B      8'h53
`define LSR_IDX_CUR_ONE     8'h54
`define LSR_IDX_CUR_TWO     8'h55
`define LSR_IDX_CUR_THREE   8'h56
`define LSR_IDX_CUR_FOUR    8'h57
`define LSR_IDX_CUR_FIVE    8'h58
`define LSR_IDX_CUR_SIX     8'h59
`define LSR_IDX_PERIOD      8'h5C
`define LSR_IDX_CONTROL     8'h5E
`define LSR_IDX_POWER       8'h5F

// ****************************************************************
// Field positions.
// ****************************************************************
`define LSR_PERIOD_FIXED_BIT 6
`define LSR_PERIOD_HI_BIT    7
`define LSR_CTRL_SEL_LSB     0
`define LSR_CTRL_EXT_BIT     4

// ****************************************************************
// Reset values.
// ****************************************************************
`define LSR_SENSE_RST        8'h00
`define LSR_PERIOD_RST       8'hFF
`define LSR_CONTROL_RST      8'h00

// ****************************************************************
// Timing in picoseconds: clock period and converter period step.
// ****************************************************************
`define LSR_CLK_PERIOD_PS    40000
`define LSR_PERIOD_STEP_PS   61035

`endif

// file: common/lsr_pkg.sv
// ****************************************************************
// Types shared by the readout block.
// ****************************************************************
package lsr_pkg;
	// One eight-bit measurement or register code.
	typedef logic [7:0] lsr_code_t;
	// APB byte address.
	typedef logic [11:0] lsr_addr_t;
	// Transistor selector for the power readout.
	typedef logic [2:0] lsr_sel_t;
	// Phase accumulator for the converter period, in picoseconds.
	typedef logic [23:0] lsr_phase_t;
endpackage : lsr_pkg

// file: logic/lsr_sense_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_map.svh"

// ****************************************************************
// Holds a bank of measurement codes, loaded on each update strobe.
// ****************************************************************
module lsr_sense_capture #(
	parameter int CHANNELS = 9
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  clkEn,
	input  wire logic                  load,
	input  wire logic [CHANNELS*8-1:0] codeIn,
	output logic      [CHANNELS*8-1:0] codeOut
);
	import lsr_pkg::*;

	// Refuse a bank with no channels.
	if (CHANNELS < 1) begin : gCheck
		$error("lsr_sense_capture needs at least one channel");
	end

	// Storage, one word per channel.
	lsr_code_t held_q [CHANNELS];

	// Every channel clears to zero and then loads the live code on each strobe.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				held_q[i] <= `LSR_SENSE_RST;
			end
		end else if (clkEn && load) begin
			for (int i = 0; i < CHANNELS; i++) begin
				held_q[i] <= codeIn[i*8 +: 8];
			end
		end
	end

	// Flatten the bank back onto the output port.
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			codeOut[i*8 +: 8] = held_q[i];
		end
	end
endmodule : lsr_sense_capture
`default_nettype wire

// file: logic/lsr_period_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_map.svh"

// ****************************************************************
// Marks the start of each converter PWM period.
// ****************************************************************
// The period step does not divide the clock, so a phase accumulator
// in picoseconds keeps the average period exact; single periods may
// jitter by one clock.
module lsr_period_gen #(
	parameter int CLK_PS  = `LSR_CLK_PERIOD_PS,
	parameter int STEP_PS = `LSR_PERIOD_STEP_PS
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              clkEn,
	input  wire lsr_pkg::lsr_code_t periodCode,
	output logic                   periodStart
);
	import lsr_pkg::*;

	// The shortest period must span more than one clock.
	if (64 * STEP_PS <= CLK_PS || 255 * STEP_PS >= (1 << 24)) begin : gChk
		$error("lsr_period_gen step or clock out of range");
	end

	localparam lsr_phase_t ClkPs  = lsr_phase_t'(CLK_PS);
	localparam lsr_phase_t StepPs = lsr_phase_t'(STEP_PS);

	lsr_phase_t phase_q;   // Time elapsed in this period.
	lsr_phase_t phase_d;   // Next elapsed time.
	lsr_phase_t target;    // Period length in picoseconds.
	lsr_phase_t sum;       // Elapsed time after this clock.
	logic       wrap;      // Period ends on this clock.

	// Period length is the code times the fixed step.
	always_comb begin
		target = lsr_phase_t'(periodCode) * StepPs;
		sum    = phase_q + ClkPs;
		wrap   = (sum >= target);
		if (!wrap) begin
			phase_d = sum;
		end else if (sum - target >= target) begin
			// A shortened period restarts cleanly.
			phase_d = '0;
		end else begin
			phase_d = sum - target;
		end
	end

	// Accumulator and the period start pulse.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			phase_q     <= '0;
			periodStart <= 1'b0;
		end else if (clkEn) begin
			phase_q     <= phase_d;
			periodStart <= wrap;
		end
	end
endmodule : lsr_period_gen
`default_nettype wire

// file: logic/lsr_readout.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_map.svh"

// ****************************************************************
// Line sense readout and converter period, APB slave.
// ****************************************************************
// Measurement codes come from the analog front end on this clock,
// qualified by senseValid. Software reads them over APB; the only
// writable state is the converter period and a small control word.
module lsr_readout (
	input  wire logic               mclk,
	input  wire logic               resetn,
	input  wire logic               clkEn,
	// APB slave.
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire lsr_pkg::lsr_addr_t paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Live measurement codes from the front end.
	input  wire logic               senseValid,
	input  wire lsr_pkg::lsr_code_t batterySenseA,
	input  wire lsr_pkg::lsr_code_t batterySenseB,
	input  wire lsr_pkg::lsr_code_t transistorCurrent1,
	input  wire lsr_pkg::lsr_code_t transistorCurrent2,
	input  wire lsr_pkg::lsr_code_t transistorCurrent3,
	input  wire lsr_pkg::lsr_code_t transistorCurrent4,
	input  wire lsr_pkg::lsr_code_t transistorCurrent5,
	input  wire lsr_pkg::lsr_code_t transistorCurrent6,
	input  wire lsr_pkg::lsr_code_t extendedBatteryOffsetCurrent,
	input  wire lsr_pkg::lsr_code_t transistorPower1,
	input  wire lsr_pkg::lsr_code_t transistorPower2,
	input  wire lsr_pkg::lsr_code_t transistorPower3,
	input  wire lsr_pkg::lsr_code_t transistorPower4,
	input  wire lsr_pkg::lsr_code_t transistorPower5,
	input  wire lsr_pkg::lsr_code_t transistorPower6,
	// Converter and front end controls.
	output lsr_pkg::lsr_code_t      converterPeriodField,
	output logic                    converterPeriodStart,
	output logic                    extendedBatteryOptionEnable
);
	import lsr_pkg::*;

	// ****************************************************************
	// Helper functions.
	// ****************************************************************

	// Byte address of a register index.
	function automatic lsr_addr_t regAddr(input lsr_code_t idx);
		regAddr = {2'h0, idx, 2'h0};
	endfunction : regAddr

	// Subtraction that stops at zero instead of wrapping.
	function automatic lsr_code_t satSub(input lsr_code_t a,
	                                     input lsr_code_t b);
		satSub = (a > b) ? a - b : 8'h00;
	endfunction : satSub

	// Widen an eight-bit register to the bus, upper bits zero.
	function automatic logic [31:0] busWord(input lsr_code_t v);
		busWord = {24'h000000, v};
	endfunction : busWord

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic              periodHi_q;     // Range select, period bit 7.
	logic [5:0]        periodLo_q;     // Period bits 5 to 0.
	logic              extEnable_q;    // Extended battery option.
	lsr_sel_t          powerSel_q;     // Power monitor selector.
	lsr_code_t         powerOut_q;     // Selected transistor power.
	logic [31:0]       prdata_q;       // Read data held for access.

	// ****************************************************************
	// Bus decode.
	// ****************************************************************
	logic              setupPhase;     // First cycle of a transfer.
	logic              accessPhase;    // Completing cycle.
	logic              writeTaken;     // Write takes effect now.
	logic              addrHit;        // Address maps a register.
	logic [31:0]       readMux;        // Read value of the address.
	lsr_code_t         periodValue;    // Full period register value.
	lsr_code_t         ctrlValue;      // Full control register value.
	lsr_code_t         powerSelected;  // Power code picked by selector.
	lsr_code_t         currentOne;     // Transistor one, corrected.
	lsr_code_t         currentTwo;     // Transistor two, corrected.
	logic [63:0]       senseLive;      // Live codes into the bank.
	logic [63:0]       senseHeld;      // Held codes out of the bank.

	// The slave answers with no wait state; a frozen clock stalls it.
	always_comb begin
		setupPhase  = psel && !penable;
		accessPhase = psel && penable;
		writeTaken  = accessPhase && pwrite && clkEn;
		pready      = clkEn;
	end

	// Unmapped addresses answer with an error; sense registers do not.
	always_comb begin
		addrHit = 1'b1;
		case (paddr)
			regAddr(`LSR_IDX_BATT_A),
			regAddr(`LSR_IDX_BATT_B),
			regAddr(`LSR_IDX_CUR_ONE),
			regAddr(`LSR_IDX_CUR_TWO),
			regAddr(`LSR_IDX_CUR_THREE),
			regAddr(`LSR_IDX_CUR_FOUR),
			regAddr(`LSR_IDX_CUR_FIVE),
			regAddr(`LSR_IDX_CUR_SIX),
			regAddr(`LSR_IDX_PERIOD),
			regAddr(`LSR_IDX_CONTROL),
			regAddr(`LSR_IDX_POWER): begin
				addrHit = 1'b1;
			end
			default: begin
				addrHit = 1'b0;
			end
		endcase
		pslverr = accessPhase && !addrHit;
	end

	// ****************************************************************
	// Measurement capture.
	// ****************************************************************

	// With the option on, the added offset is left out of one and two.
	always_comb begin
		if (extEnable_q) begin
			currentOne = satSub(transistorCurrent1,
			                    extendedBatteryOffsetCurrent);
			currentTwo = satSub(transistorCurrent2,
			                    extendedBatteryOffsetCurrent);
		end else begin
			currentOne = transistorCurrent1;
			currentTwo = transistorCurrent2;
		end
	end

	// Bank order: battery a, b, then transistors one to six.
	always_comb begin
		senseLive = {transistorCurrent6, transistorCurrent5,
		             transistorCurrent4, transistorCurrent3,
		             currentTwo, currentOne,
		             batterySenseB, batterySenseA};
	end

	// The bank of read-only sense registers.
	lsr_sense_capture #(
		.CHANNELS (8)
	) uCapture (
		.mclk    (mclk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.load    (senseValid),
		.codeIn  (senseLive),
		.codeOut (senseHeld)
	);

	// Selector codes six and seven read as zero.
	always_comb begin
		case (powerSel_q)
			3'h0:    powerSelected = transistorPower1;
			3'h1:    powerSelected = transistorPower2;
			3'h2:    powerSelected = transistorPower3;
			3'h3:    powerSelected = transistorPower4;
			3'h4:    powerSelected = transistorPower5;
			3'h5:    powerSelected = transistorPower6;
			default: powerSelected = 8'h00;
		endcase
	end

	// The power readout follows the selected transistor.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			powerOut_q <= `LSR_SENSE_RST;
		end else if (clkEn && senseValid) begin
			powerOut_q <= powerSelected;
		end
	end

	// ****************************************************************
	// Writable registers.
	// ****************************************************************

	// Period: bits 7 and 5..0 take writes; bit 6 has no storage.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			periodHi_q <= 1'(`LSR_PERIOD_RST >> `LSR_PERIOD_HI_BIT);
			periodLo_q <= 6'(`LSR_PERIOD_RST);
		end else if (writeTaken
		             && paddr == regAddr(`LSR_IDX_PERIOD)) begin
			periodHi_q <= pwdata[`LSR_PERIOD_HI_BIT];
			periodLo_q <= pwdata[5:0];
		end
	end

	// Control word: extended option enable and power selector.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			extEnable_q <= 1'(`LSR_CONTROL_RST >> `LSR_CTRL_EXT_BIT);
			powerSel_q  <= 3'(`LSR_CONTROL_RST);
		end else if (writeTaken
		             && paddr == regAddr(`LSR_IDX_CONTROL)) begin
			extEnable_q <= pwdata[`LSR_CTRL_EXT_BIT];
			powerSel_q  <= pwdata[`LSR_CTRL_SEL_LSB +: 3];
		end
	end

	// Bit six is fixed high, so codes stay in 0x40..0x7F or 0xC0..0xFF; which half
	// is used depends on the converter switch that software fits.
	always_comb begin
		periodValue = {periodHi_q, 1'b1, periodLo_q};
		ctrlValue   = 8'h00;
		ctrlValue[`LSR_CTRL_EXT_BIT] = extEnable_q;
		ctrlValue[`LSR_CTRL_SEL_LSB +: 3] = powerSel_q;
	end

	// ****************************************************************
	// Read path.
	// ****************************************************************

	// Read multiplexer; sense registers hold no write path at all.
	always_comb begin
		case (paddr)
			regAddr(`LSR_IDX_BATT_A):
				readMux = busWord(senseHeld[7:0]);
			regAddr(`LSR_IDX_BATT_B):
				readMux = busWord(senseHeld[15:8]);
			regAddr(`LSR_IDX_CUR_ONE):
				readMux = busWord(senseHeld[23:16]);
			regAddr(`LSR_IDX_CUR_TWO):
				readMux = busWord(senseHeld[31:24]);
			regAddr(`LSR_IDX_CUR_THREE):
				readMux = busWord(senseHeld[39:32]);
			regAddr(`LSR_IDX_CUR_FOUR):
				readMux = busWord(senseHeld[47:40]);
			regAddr(`LSR_IDX_CUR_FIVE):
				readMux = busWord(senseHeld[55:48]);
			regAddr(`LSR_IDX_CUR_SIX):
				readMux = busWord(senseHeld[63:56]);
			regAddr(`LSR_IDX_PERIOD):
				readMux = busWord(periodValue);
			regAddr(`LSR_IDX_CONTROL):
				readMux = busWord(ctrlValue);
			regAddr(`LSR_IDX_POWER):
				readMux = busWord(powerOut_q);
			default:
				readMux = 32'h00000000;
		endcase
	end

	// Read data is captured in the setup cycle and stands in access.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= 32'h00000000;
		end else if (clkEn && setupPhase && !pwrite) begin
			prdata_q <= readMux;
		end
	end

	// Registered read data to the bus.
	always_comb begin
		prdata = prdata_q;
	end

	// ****************************************************************
	// Converter period and control outputs.
	// ****************************************************************

	// Period start pulses from the period register.
	lsr_period_gen uPeriod (
		.mclk        (mclk),
		.resetn      (resetn),
		.clkEn       (clkEn),
		.periodCode  (periodValue),
		.periodStart (converterPeriodStart)
	);

	// Register-driven control outputs.
	always_comb begin
		converterPeriodField        = periodValue;
		extendedBatteryOptionEnable = extEnable_q;
	end
endmodule : lsr_readout
`default_nettype wire

// file: verif/lsr_readout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the readout block.
// ****************************************************************
module lsr_readout_monitor (
	input wire logic               mclk,
	input wire logic               resetn,
	input wire logic               clkEn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire lsr_pkg::lsr_addr_t paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               senseValid,
	input wire lsr_pkg::lsr_code_t batterySenseA,
	input wire lsr_pkg::lsr_code_t transistorCurrent1,
	input wire lsr_pkg::lsr_code_t extendedBatteryOffsetCurrent,
	input wire lsr_pkg::lsr_code_t converterPeriodField,
	input wire logic               converterPeriodStart,
	input wire logic               extendedBatteryOptionEnable
);
	import lsr_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	wire logic       access = psel && penable && pready; // Transfer ends.
	wire logic [7:0] wrByte = pwdata[7:0];  // Written register byte.
	wire logic       wrExt  = pwdata[4];    // Written option bit.
	wire logic       mapped = paddr[1:0] == 2'b00 && (paddr == 12'h170
		|| paddr >= 12'h148 && paddr <= 12'h164
		|| paddr == 12'h178 || paddr == 12'h17C);
	lsr_code_t  battQ;  // What battery register A should hold.
	lsr_code_t  cur1Q;  // What transistor one register should hold.
	lsr_code_t  codeQ;  // Period field one cycle ago.
	logic [9:0] gapQ;   // Cycles since the last period start.
	logic [1:0] okQ;    // Starts seen since the field last moved.

	// Mirrors the capture, with the offset removed when enabled.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			battQ <= 8'h00;
			cur1Q <= 8'h00;
		end else if (senseValid && clkEn) begin
			battQ <= batterySenseA;
			cur1Q <= !extendedBatteryOptionEnable ? transistorCurrent1 :
				transistorCurrent1 > extendedBatteryOffsetCurrent ?
				transistorCurrent1 - extendedBatteryOffsetCurrent : 8'h00;
		end
	end

	// Measures start spacing; a moved field or a stall restarts it.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			gapQ  <= 10'h000;
			okQ   <= 2'h0;
			codeQ <= 8'hFF;
		end else begin
			gapQ  <= converterPeriodStart ? 10'h001 :
				gapQ + {9'h000, gapQ != 10'h3FF};
			codeQ <= converterPeriodField;
			if (converterPeriodField != codeQ || !clkEn) begin
				okQ <= 2'h0;
			end else if (converterPeriodStart && okQ != 2'h3) begin
				okQ <= okQ + 2'h1;
			end
		end
	end

	sequence readSetup(lsr_addr_t a);
		psel && !penable && !pwrite && clkEn && !senseValid && paddr == a;
	endsequence
	sequence writeEnd(lsr_addr_t a);
		access && pwrite && paddr == a;
	endsequence

	batt_read_a: assert property (
		readSetup(12'h148) |=> prdata == {24'h000000, battQ})
		else $error("Battery code read back wrong.");
	cur_one_read_a: assert property (
		readSetup(12'h150) |=> prdata == {24'h000000, cur1Q})
		else $error("Transistor one code read back wrong.");
	bit_six_a: assert property (
		converterPeriodField[6])
		else $error("Period bit six is not one.");
	period_write_a: assert property (
		writeEnd(12'h170) |=> converterPeriodField == ($past(wrByte) | 8'h40))
		else $error("Period write not applied.");
	period_hold_a: assert property (
		!(access && pwrite && paddr == 12'h170) |=> $stable(converterPeriodField))
		else $error("Period field moved without a write.");
	period_gap_a: assert property (
		converterPeriodStart && okQ >= 2'h2 && converterPeriodField == codeQ
		|-> 40000 * int'(gapQ) <= 61035 * int'(codeQ) + 40000
		&& 40000 * int'(gapQ) + 40000 >= 61035 * int'(codeQ))
		else $error("Period start spacing wrong.");
	start_pulse_a: assert property (
		converterPeriodStart |=> !converterPeriodStart)
		else $error("Period start wider than one cycle.");
	no_error_a: assert property (
		access && mapped |-> !pslverr)
		else $error("Error on a mapped register.");
	unmapped_err_a: assert property (
		access && !mapped |-> pslverr)
		else $error("No error on an unmapped address.");
	enable_write_a: assert property (
		writeEnd(12'h178) |=> extendedBatteryOptionEnable == $past(wrExt))
		else $error("Option enable write not applied.");
endmodule : lsr_readout_monitor

bind lsr_readout lsr_readout_monitor u_lsr_readout_monitor (.mclk, .resetn,
	.clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .senseValid, .batterySenseA, .transistorCurrent1,
	.extendedBatteryOffsetCurrent, .converterPeriodField,
	.converterPeriodStart, .extendedBatteryOptionEnable);
`default_nettype wire

// file: verif/lsr_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the readout block.
// ****************************************************************
module lsr_readout_test;
	import lsr_pkg::*;
	logic        mclk = 1'b0, resetn = 1'b0, clkEn = 1'b1, senseValid = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	lsr_addr_t   paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, seed = 32'h0001007E;
	logic        pready, pslverr, periodStart, extEn;
	lsr_code_t   v[15], e[15], periodField, codes[6];  // Live and expected.
	logic [32:0] expQ[$];  // Expected {error, data} per transfer.
	int          fails = 0, nTests = 0, k;

	always #20 mclk = ~mclk;

	lsr_readout u_lsr_readout (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.senseValid(senseValid), .batterySenseA(v[0]), .batterySenseB(v[1]),
		.transistorCurrent1(v[2]), .transistorCurrent2(v[3]),
		.transistorCurrent3(v[4]), .transistorCurrent4(v[5]),
		.transistorCurrent5(v[6]), .transistorCurrent6(v[7]),
		.extendedBatteryOffsetCurrent(v[8]), .transistorPower1(v[9]),
		.transistorPower2(v[10]), .transistorPower3(v[11]),
		.transistorPower4(v[12]), .transistorPower5(v[13]),
		.transistorPower6(v[14]), .converterPeriodField(periodField),
		.converterPeriodStart(periodStart),
		.extendedBatteryOptionEnable(extEn));

	// Xorshift source of stimulus values.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Current code with the offset taken off, floored at zero.
	function automatic lsr_code_t sat(input lsr_code_t a, input lsr_code_t b);
		return a > b ? a - b : 8'h00;
	endfunction : sat

	// Reports and counts one comparison.
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		nTests++;
		if (seen !== want) begin
			fails++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, want);
		end
	endtask : check

	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (fails == 0 && nTests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test

	// One APB transfer; the expected result is queued for the watcher.
	task automatic apb(input logic wr, input lsr_addr_t a, input lsr_code_t d,
		input logic [32:0] want);
		int          n;
		logic [31:0] r;
		r = rnd();
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {r[31:8], d};
		expQ.push_back(want);
		@(posedge mclk);
		penable <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (n == 64) begin
			fails++;
			stop_test();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input lsr_addr_t a, input lsr_code_t want);
		apb(1'b0, a, 8'h00, {1'b0, 24'h000000, want});
	endtask : rd

	task automatic wr(input lsr_addr_t a, input lsr_code_t d);
		apb(1'b1, a, d, 33'h000000000);
	endtask : wr

	// Captures fresh codes, then scrambles the live inputs.
	task automatic load();
		int          i;
		logic [31:0] r;
		@(posedge mclk);
		for (i = 0; i < 15; i++) begin
			r = rnd();
			e[i] = r[7:0];
			v[i] <= r[7:0];
		end
		senseValid <= 1'b1;
		@(posedge mclk);
		senseValid <= 1'b0;
		for (i = 0; i < 15; i++) v[i] <= ~e[i];
	endtask : load

	// Reads the eight sense registers back.
	task automatic sense(input logic ext);
		int i;
		for (i = 0; i < 8; i++) begin
			rd(lsr_addr_t'(12'h148 + 4 * i), (ext && (i == 2 || i == 3)) ?
				sat(e[i], e[8]) : e[i]);
		end
	endtask : sense

	// Watcher: each finished transfer is compared with the oldest note.
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (expQ.size() == 0) check(33'h000000000, 33'h000000001);
			else check({pslverr, pwrite ? 32'h00000000 : prdata},
				expQ.pop_front());
		end
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		foreach (v[i]) v[i] = 8'h00;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		for (k = 0; k < 8; k++) rd(lsr_addr_t'(12'h148 + 4 * k), 8'h00);
		rd(12'h170, 8'hFF);
		apb(1'b0, 12'h168, 8'h00, {1'b1, 32'h00000000});
		apb(1'b1, 12'h000, 8'h5A, {1'b1, 32'h00000000});
		load();
		sense(1'b0);
		for (k = 0; k < 8; k++) wr(lsr_addr_t'(12'h148 + 4 * k), 8'hA5);
		sense(1'b0);
		wr(12'h178, 8'h10);
		rd(12'h178, 8'h10);
		check({32'h00000000, extEn}, 33'h000000001);
		load();
		sense(1'b1);
		wr(12'h178, 8'hFF);
		rd(12'h178, 8'h17);
		for (k = 0; k < 8; k++) begin
			wr(12'h178, {5'h00, k[2:0]});
			load();
			rd(12'h17C, k < 6 ? e[9 + k] : 8'h00);
		end
		// Period codes at both ends of the low range and the top of the high one, some with bit six cleared.
		codes = '{8'h00, 8'h3F, 8'h40, 8'hBF, 8'hFF, 8'hA7};
		foreach (codes[i]) begin
			wr(12'h170, codes[i]);
			rd(12'h170, codes[i] | 8'h40);
			check({25'h0, periodField}, {25'h0, codes[i] | 8'h40});
			repeat (1300) @(posedge mclk);
		end
		// A read stalled in its access phase by the clock enable.
		fork
			rd(12'h148, e[0]);
			begin
				repeat (2) @(posedge mclk);
				clkEn <= 1'b0;
				repeat (3) @(posedge mclk);
				clkEn <= 1'b1;
			end
		join
		stop_test();
	end
endmodule : lsr_readout_test
`default_nettype wire
